// ===== design/temp_readout_pkg.sv
// Constants and types shared by the ambient temperature readout block.
// Assumes a 25 MHz system clock and a two-wire bus clock well below it.
package temp_readout_pkg;
  localparam logic [7:0] PTR_AMBIENT = 8'h05;
  localparam logic [7:0] PTR_MAKER = 8'h06;
  // Bus address of this device; the value is arbitrary.
  localparam logic [6:0] DEV_ADDR = 7'h2a;
  // Maker code; the value is arbitrary.
  localparam logic [15:0] MAKER_CODE = 16'h00a5;
  localparam logic [15:0] AMBIENT_RESET = 16'h0000;
  localparam int CRIT_BIT = 15;
  localparam int UPPER_BIT = 14;
  localparam int LOWER_BIT = 13;
  localparam int TEMP_MSB = 12;
  localparam logic [1:0] RES_HALF = 2'h0;
  localparam logic [1:0] RES_QUARTER = 2'h1;
  localparam logic [1:0] RES_EIGHTH = 2'h2;
  localparam logic [12:0] MASK_HALF = 13'h1ff8;
  localparam logic [12:0] MASK_QUARTER = 13'h1ffc;
  localparam logic [12:0] MASK_EIGHTH = 13'h1ffe;
  localparam logic [12:0] MASK_FULL = 13'h1fff;
  localparam logic [2:0] LAST_BIT = 3'h7;

  typedef struct packed {
    logic [10:0] crit;
    logic [10:0] upper;
    logic [10:0] lower;
  } limits_t;

  typedef enum logic [6:0] {
    ST_IDLE = 7'b0000001,
    ST_ADDR = 7'b0000010,
    ST_ACK = 7'b0000100,
    ST_PTR = 7'b0001000,
    ST_WDATA = 7'b0010000,
    ST_READ = 7'b0100000,
    ST_RACK = 7'b1000000
  } bus_state_t;
endpackage

// ===== design/ambient_temp_result_readout.sv
// Ambient temperature result register with its two-wire bus slave.
// Assumes the converter gives a result word with a one-cycle strobe on mclk,
// and that bus pins arrive asynchronously and are resolved outside.
//
// Operation
// [R1] Hold 16-bit result, 13-bit signed temperature.
// [R2] Reads never see a half-updated value.
// [R3] Load each converter result in parallel.
// [R4] Bit 15 set when reading at/above critical.
// [R5] Bit 14 set when reading above upper.
// [R6] Bit 13 set when reading below lower.
// [R7] Bit 12 is the sign.
// [R8] Bits 11..0 weight 2^7 down to 2^-4.
// [R9] Flags ignore all alert configuration settings.
// [R10] Unused low fraction bits forced to zero.
// [R11] Host writes pointer 0x05, then repeated start.
// [R12] Upper byte first, host acks, then nak.
// [R13] Host masks flags and converts bytes itself.
// [R14] Fixed read-only maker code at pointer 0x06.
// [R15] Resolution code selects step and zeroed bits.
// [R16] Limits are 11-bit signed quarter-degree values.
// [R17] Writes to these registers are ignored.
// [R18] Flags load together with the temperature.
`timescale 1ns/1ps
module ambient_temp_result_readout (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic convDone,
  input wire logic [12:0] convData,
  input wire logic [1:0] resolution,
  input wire temp_readout_pkg::limits_t limits,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  output logic [15:0] ambientReg
);
  logic [1:0] rstSync_q;
  logic rstN;
  logic [1:0] sclSync_q;
  logic [1:0] sdaSync_q;
  logic sclPrev_q;
  logic sdaPrev_q;
  logic sclRise;
  logic sclFall;
  logic startSeen;
  logic stopSeen;
  logic [15:0] ambient_q;
  logic [12:0] mask;
  logic signed [12:0] sample;
  logic signed [12:0] critS;
  logic signed [12:0] upperS;
  logic signed [12:0] lowerS;
  temp_readout_pkg::bus_state_t state_q;
  temp_readout_pkg::bus_state_t after_q;
  logic [2:0] bitCnt_q;
  logic [7:0] rxShift_q;
  logic gotByte_q;
  logic firstRead_q;
  logic isPtr_q;
  logic [7:0] ptr_q;
  logic [15:0] snap_q;
  logic [7:0] tx_q;
  logic sdaOe_q;
  logic sdaOut_q;

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      rstSync_q <= 2'h0;
    else
      rstSync_q <= {rstSync_q[0], 1'b1};
  end
  assign rstN = rstSync_q[1];

  // Pins are asynchronous, so only the second stage feeds logic.
  always_ff @(posedge mclk or negedge rstN)
  begin
    if (!rstN)
    begin
      sclSync_q <= 2'h3;
      sdaSync_q <= 2'h3;
      sclPrev_q <= 1'b1;
      sdaPrev_q <= 1'b1;
    end
    else
    begin
      sclSync_q <= {sclSync_q[0], sclIn};
      sdaSync_q <= {sdaSync_q[0], sdaIn};
      sclPrev_q <= sclSync_q[1];
      sdaPrev_q <= sdaSync_q[1];
    end
  end
  assign sclRise = sclSync_q[1] & ~sclPrev_q;
  assign sclFall = ~sclSync_q[1] & sclPrev_q;
  assign startSeen = sclSync_q[1] & sclPrev_q & sdaPrev_q & ~sdaSync_q[1];
  assign stopSeen = sclSync_q[1] & sclPrev_q & ~sdaPrev_q & sdaSync_q[1];

  always_comb
  begin
    case (resolution) // [R15] [R10]
      temp_readout_pkg::RES_HALF: mask = temp_readout_pkg::MASK_HALF;
      temp_readout_pkg::RES_QUARTER: mask = temp_readout_pkg::MASK_QUARTER;
      temp_readout_pkg::RES_EIGHTH: mask = temp_readout_pkg::MASK_EIGHTH;
      default: mask = temp_readout_pkg::MASK_FULL;
    endcase
  end
  assign sample = signed'(convData & mask); // [R10]
  // Limits gain two zero fraction bits to match the result scale.
  assign critS = signed'({limits.crit, 2'h0}); // [R16]
  assign upperS = signed'({limits.upper, 2'h0}); // [R16]
  assign lowerS = signed'({limits.lower, 2'h0}); // [R16]

  // No alert configuration reaches this logic, so the flags always report.
  always_ff @(posedge mclk or negedge rstN)
  begin
    if (!rstN)
      ambient_q <= temp_readout_pkg::AMBIENT_RESET;
    else if (convDone) // [R3] [R18] [R9]
    begin
      ambient_q[temp_readout_pkg::CRIT_BIT] <= sample >= critS; // [R4]
      ambient_q[temp_readout_pkg::UPPER_BIT] <= sample > upperS; // [R5]
      ambient_q[temp_readout_pkg::LOWER_BIT] <= sample < lowerS; // [R6]
      ambient_q[temp_readout_pkg::TEMP_MSB:0] <= sample; // [R1] [R7] [R8]
    end
  end

  // Bus slave: data is sampled on rising and changed on falling bus clock.
  always_ff @(posedge mclk or negedge rstN)
  begin
    if (!rstN)
    begin
      state_q <= temp_readout_pkg::ST_IDLE;
      after_q <= temp_readout_pkg::ST_IDLE;
      bitCnt_q <= 3'h0;
      rxShift_q <= 8'h00;
      gotByte_q <= 1'b0;
      firstRead_q <= 1'b0;
      isPtr_q <= 1'b0;
      ptr_q <= 8'h00;
      snap_q <= 16'h0000;
      tx_q <= 8'h00;
      sdaOe_q <= 1'b0;
    end
    else if (startSeen)
    begin
      state_q <= temp_readout_pkg::ST_ADDR;
      bitCnt_q <= 3'h0;
      gotByte_q <= 1'b0;
      sdaOe_q <= 1'b0;
    end
    else if (stopSeen)
    begin
      state_q <= temp_readout_pkg::ST_IDLE;
      sdaOe_q <= 1'b0;
    end
    else
    begin
      case (state_q)
        temp_readout_pkg::ST_ADDR, temp_readout_pkg::ST_PTR, temp_readout_pkg::ST_WDATA:
        begin
          if (sclRise)
          begin
            rxShift_q <= {rxShift_q[6:0], sdaSync_q[1]};
            bitCnt_q <= bitCnt_q + 3'h1;
            gotByte_q <= (bitCnt_q == temp_readout_pkg::LAST_BIT);
          end
          else if (sclFall && gotByte_q)
          begin
            gotByte_q <= 1'b0;
            isPtr_q <= 1'b0;
            if (state_q != temp_readout_pkg::ST_ADDR)
            begin
              sdaOe_q <= 1'b1;
              state_q <= temp_readout_pkg::ST_ACK;
              after_q <= temp_readout_pkg::ST_WDATA;
              // Later data bytes are acknowledged and dropped.
              if (state_q == temp_readout_pkg::ST_PTR)
                ptr_q <= rxShift_q; // [R11]
            end
            else if (rxShift_q[7:1] == temp_readout_pkg::DEV_ADDR)
            begin
              sdaOe_q <= 1'b1;
              state_q <= temp_readout_pkg::ST_ACK;
              if (rxShift_q[0]) // [R12]
              begin
                after_q <= temp_readout_pkg::ST_READ;
                firstRead_q <= 1'b1;
                // The snapshot keeps both bytes of one read from one load.
                if (ptr_q == temp_readout_pkg::PTR_AMBIENT)
                  snap_q <= ambient_q; // [R2]
                else if (ptr_q == temp_readout_pkg::PTR_MAKER)
                  snap_q <= temp_readout_pkg::MAKER_CODE; // [R14]
                else
                  snap_q <= 16'h0000;
              end
              else
                after_q <= temp_readout_pkg::ST_PTR;
            end
            else
              state_q <= temp_readout_pkg::ST_IDLE;
          end
        end
        temp_readout_pkg::ST_ACK:
        begin
          if (sclFall)
          begin
            state_q <= after_q;
            bitCnt_q <= 3'h0;
            sdaOe_q <= 1'b0;
            if (after_q == temp_readout_pkg::ST_READ)
            begin
              tx_q <= snap_q[15:8]; // [R12]
              sdaOe_q <= ~snap_q[15];
              firstRead_q <= 1'b0;
            end
          end
        end
        temp_readout_pkg::ST_READ:
        begin
          if (sclFall)
          begin
            if (bitCnt_q == temp_readout_pkg::LAST_BIT)
            begin
              sdaOe_q <= 1'b0;
              state_q <= temp_readout_pkg::ST_RACK;
            end
            else
            begin
              bitCnt_q <= bitCnt_q + 3'h1;
              tx_q <= {tx_q[6:0], 1'b0};
              sdaOe_q <= ~tx_q[6];
            end
          end
        end
        temp_readout_pkg::ST_RACK:
        begin
          if (sclRise)
            isPtr_q <= ~sdaSync_q[1];
          else if (sclFall)
          begin
            // After the low byte the sequence repeats from the upper byte.
            if (isPtr_q) // [R12]
            begin
              state_q <= temp_readout_pkg::ST_READ;
              bitCnt_q <= 3'h0;
              firstRead_q <= ~firstRead_q;
              tx_q <= firstRead_q ? snap_q[15:8] : snap_q[7:0];
              sdaOe_q <= firstRead_q ? ~snap_q[15] : ~snap_q[7];
            end
            else
              state_q <= temp_readout_pkg::ST_IDLE;
          end
        end
        default:
          state_q <= temp_readout_pkg::ST_IDLE;
      endcase
    end
  end

  // The pin is open drain, so only the low level is ever driven.
  always_ff @(posedge mclk or negedge rstN)
  begin
    if (!rstN)
      sdaOut_q <= 1'b0;
    else
      sdaOut_q <= 1'b0;
  end

  assign sdaOut = sdaOut_q;
  assign sdaOe = sdaOe_q;
  assign ambientReg = ambient_q; // [R17]
endmodule

// ===== sim/ambient_temp_result_readout_assertions.sv
// Concurrent checks on the ambient result readout ports.
// Assumes one mclk domain and that reset clears the result register.
`timescale 1ns/1ps
module ambient_temp_result_readout_assertions (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic convDone,
  input wire logic [12:0] convData,
  input wire logic [1:0] resolution,
  input wire temp_readout_pkg::limits_t limits,
  input wire logic sclIn,
  input wire logic sdaOut,
  input wire logic sdaOe,
  input wire logic [15:0] ambientReg
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  logic signed [12:0] s;
  assign s = convData & (13'h1fff << (2'h3 - resolution));
  sequence strobeS;
    convDone;
  endsequence
  sequence sclHighS;
    sclIn [*4];
  endsequence
  load_value_a: assert property (strobeS |=> ambientReg[12:0] == $past(s))
    else $error("Loaded sample differs.");
  sign_bit_a: assert property (strobeS |=> ambientReg[12] == $past(convData[12]))
    else $error("Sign bit wrong.");
  crit_flag_a: assert property (strobeS |=>
    ambientReg[15] == $past(s >= $signed({limits.crit, 2'b00}))) else $error("Crit flag wrong.");
  upper_flag_a: assert property (strobeS |=>
    ambientReg[14] == $past(s > $signed({limits.upper, 2'b00}))) else $error("Upper flag wrong.");
  lower_flag_a: assert property (strobeS |=>
    ambientReg[13] == $past(s < $signed({limits.lower, 2'b00}))) else $error("Lower flag wrong.");
  result_hold_a: assert property (!convDone |=> $stable(ambientReg))
    else $error("Result changed without a strobe.");
  open_drain_a: assert property (sdaOut == 1'b0)
    else $error("Data pin driven high.");
  bus_stable_a: assert property (sclHighS |-> $stable(sdaOe))
    else $error("Data changed while clock high.");
endmodule

bind ambient_temp_result_readout ambient_temp_result_readout_assertions asrt (.mclk(mclk),
  .arst_n(arst_n), .convDone(convDone), .convData(convData), .resolution(resolution),
  .limits(limits), .sclIn(sclIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .ambientReg(ambientReg));

// ===== sim/two_wire_host.sv
// Behavioural two-wire bus host that reads and writes device registers.
// Assumes a pull-up on the data line; the clock stands high between frames.
`timescale 1ns/1ps
module two_wire_host (
  output logic scl,
  output logic sda,
  input wire logic sdaLine
);
  initial
  begin
    scl = 1'b1;
    sda = 1'b1;
  end
  // One bit slot of 320 ns; driving one releases the line so the device may answer.
  task automatic bitSlot(input logic b, output logic r);
    sda = b;
    #80 scl = 1'b1;
    #80 r = sdaLine;
    #80 scl = 1'b0;
    #80;
  endtask
  task automatic byteSlot(input logic [7:0] d, input logic a, output logic [7:0] q,
    output logic acked);
    logic r;
    for (int i = 7; i >= 0; i--)
      bitSlot(d[i], q[i]);
    bitSlot(a, r);
    acked = !r;
  endtask
  task automatic edgeCond(input logic first);
    sda = first;
    #80 scl = 1'b1;
    #80 sda = !first;
    #80 scl = first ? 1'b0 : 1'b1;
    #80;
  endtask
  task automatic rw(input logic [7:0] ptr, input logic wr, input logic [7:0] wd,
    output logic [15:0] rd, output logic ok);
    logic [7:0] q;
    logic a0, a1, a2;
    #17 edgeCond(1'b1);
    byteSlot({temp_readout_pkg::DEV_ADDR, 1'b0}, 1'b1, q, a0);
    byteSlot(ptr, 1'b1, q, a1);
    if (wr)
      byteSlot(wd, 1'b1, q, a2);
    else
    begin
      edgeCond(1'b1);
      byteSlot({temp_readout_pkg::DEV_ADDR, 1'b1}, 1'b1, q, a2);
      byteSlot(8'hff, 1'b0, rd[15:8], a0);
      byteSlot(8'hff, 1'b1, rd[7:0], a0);
    end
    ok = a1 & a2;
    edgeCond(1'b0);
  endtask
endmodule

// ===== sim/ambient_temp_result_readout_tb.sv
// Self-checking bench for the ambient result readout and its bus slave.
// Assumes the host model and the bound checker are compiled with it.
`timescale 1ns/1ps
module ambient_temp_result_readout_tb;
  logic mclk, rstN, convDone, scl, hostSda, sdaOut, sdaOe, ok;
  logic [12:0] convData, d;
  logic [1:0] resolution;
  logic [15:0] ambientReg, last, old, g;
  temp_readout_pkg::limits_t limits, lim;
  int mismatches, nChecks, cycles, t;
  wire sdaLine = hostSda & !(sdaOe & !sdaOut);
  ambient_temp_result_readout dut (.mclk(mclk), .arst_n(rstN), .convDone(convDone),
    .convData(convData), .resolution(resolution), .limits(limits), .sclIn(scl),
    .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe), .ambientReg(ambientReg));
  two_wire_host host (.scl(scl), .sda(hostSda), .sdaLine(sdaLine));
  always #20 mclk = ~mclk;
  function automatic logic [15:0] expv(logic [12:0] v, logic [1:0] r,
    temp_readout_pkg::limits_t l);
    logic signed [12:0] s;
    s = v & (13'h1fff << (2'h3 - r));
    return {s >= $signed({l.crit, 2'b00}), s > $signed({l.upper, 2'b00}),
      s < $signed({l.lower, 2'b00}), s};
  endfunction
  // Host-side conversion: flags dropped, negative readings give their magnitude in sixteenths.
  function automatic int hostTemp(logic [15:0] w);
    logic [7:0] ub;
    ub = w[15:8] & 8'h1f;
    if (ub[4])
      return 4096 - ((ub & 8'h0f) * 256 + w[7:0]);
    return ub * 256 + w[7:0];
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    nChecks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conv(input logic [12:0] v, input logic [1:0] r,
    input temp_readout_pkg::limits_t l);
    @(posedge mclk);
    convDone <= 1'b1;
    convData <= v;
    resolution <= r;
    limits <= l;
    @(posedge mclk);
    convDone <= 1'b0;
    #1 chk(ambientReg, expv(v, r, l));
    last = expv(v, r, l);
  endtask
  task closeOut;
    $display("Checks %0d, mismatches %0d", nChecks, mismatches);
    if (mismatches == 0 && nChecks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // The ceiling allows about six bus frames and the conversion loop twice over.
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      mismatches++;
      closeOut();
    end
  end
  initial
  begin
    {mclk, rstN, convDone, convData, resolution, limits} = '0;
    void'($urandom(32'hb3cd));
    repeat (4) @(posedge mclk);
    rstN <= 1'b1;
    #1 chk(ambientReg, temp_readout_pkg::AMBIENT_RESET);
    repeat (4) @(posedge mclk);
    // Corners land exactly on each limit unless half resolution masks off its quarter bit; on a limit the three flags use different comparisons.
    for (int i = 0; i < 24; i++)
    begin
      lim = 33'({$urandom(), $urandom()});
      d = i % 4 == 1 ? {lim.upper, 2'b00} : i % 4 == 2 ? {lim.lower, 2'b00} : 13'($urandom());
      conv(i % 4 == 3 ? {lim.crit, 2'b00} : d, 2'(i >> 2), lim);
    end
    host.rw(temp_readout_pkg::PTR_AMBIENT, 1'b0, 8'h00, g, ok);
    chk(g, last);
    chk(16'(ok), 16'h0001);
    t = $signed(last[12:0]);
    chk(16'(hostTemp(g)), 16'(t < 0 ? -t : t));
    old = last;
    fork
      host.rw(temp_readout_pkg::PTR_AMBIENT, 1'b0, 8'h00, g, ok);
      begin
        #10000;
        conv(13'h1f35, 2'h3, lim);
      end
    join
    chk(g, old);
    host.rw(temp_readout_pkg::PTR_AMBIENT, 1'b1, 8'h5a, g, ok);
    chk(ambientReg, last);
    chk(16'(ok), 16'h0001);
    host.rw(temp_readout_pkg::PTR_MAKER, 1'b1, 8'h33, g, ok);
    host.rw(temp_readout_pkg::PTR_MAKER, 1'b0, 8'h00, g, ok);
    chk(g, temp_readout_pkg::MAKER_CODE);
    host.rw(8'h07, 1'b0, 8'h00, g, ok);
    chk(g, 16'h0000);
    closeOut();
  end
endmodule
